// file: hdl/iocs_cfg.svh
// constants for the internal oscillator clock switch
`ifndef IOCS_CFG_SVH
`define IOCS_CFG_SVH

// ----------------------------------------------------------------------
// register map
// ----------------------------------------------------------------------
`define IOCS_OSC_CONTROL_ADDR 8'h00
`define IOCS_OSC_STATUS_ADDR 8'h04
`define IOCS_IRCF_MSB 6
`define IOCS_IRCF_LSB 3
`define IOCS_SCS_MSB 1
`define IOCS_SCS_LSB 0
`define IOCS_SCS_INT_BIT 1
`define IOCS_STAT_HF_READY_BIT 4
`define IOCS_STAT_LF_READY_BIT 1
`define IOCS_STAT_HF_STABLE_BIT 0
`define IOCS_IRCF_RESET 4'h7
`define IOCS_SCS_RESET 2'h0
`define IOCS_SCS_SECONDARY 2'h1

// ----------------------------------------------------------------------
// frequency select decode
// ----------------------------------------------------------------------
`define IOCS_IRCF_HF_LOW 4'h8
`define IOCS_IRCF_MID_LOW 4'h4
`define IOCS_IRCF_LF_TOP 4'h2
`define IOCS_TAP_HF_BASE 4'hf
`define IOCS_TAP_MID_BASE 4'hc
`define IOCS_TAP_SLOW 4'h9

// ----------------------------------------------------------------------
// pin indices in the sampled oscillator vector
// ----------------------------------------------------------------------
`define IOCS_PIN_CFG 0
`define IOCS_PIN_SEC 1
`define IOCS_PIN_HF 2
`define IOCS_PIN_LF 3
`define IOCS_PIN_TOL 4

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define IOCS_MCLK_MHZ 50
`define IOCS_HF_STARTUP_NS 2000
`define IOCS_HF_STARTUP_CYC ((`IOCS_HF_STARTUP_NS * `IOCS_MCLK_MHZ + 999) / 1000)
`define IOCS_LF_STARTUP_EDGES 7'h01
`define IOCS_EXT_STARTUP_EDGES 7'h02

`endif

// file: hdl/iocs_pkg.sv
// types for the internal oscillator clock switch
`default_nettype none

package iocs_pkg;

	// ------------------------------------------------------------------
	// clock sources and switch sequence
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		SRC_CFG,
		SRC_SEC,
		SRC_HF,
		SRC_LF
	} iocs_src_e;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_STARTUP,
		ST_WAIT_FALL,
		ST_WAIT_RISE,
		ST_UPDATE
	} iocs_fsm_e;

	// ------------------------------------------------------------------
	// whole state of the block
	// ------------------------------------------------------------------
	typedef struct packed {
		iocs_fsm_e fsm;
		logic [4:0] sync1;
		logic [4:0] sync2;
		logic [4:0] sync3;
		logic [4:0] filt;
		logic [4:0] prev;
		logic [8:0] div;
		logic [3:0] ircf;
		logic [1:0] scs;
		iocs_src_e act_src;
		logic [3:0] act_tap;
		iocs_src_e tgt_src;
		logic [3:0] tgt_tap;
		logic act_prev;
		logic tgt_prev;
		logic [6:0] cnt;
		logic hf_on;
		logic lf_on;
		logic hf_flag;
		logic lf_flag;
		logic sysclk;
		logic [7:0] rdata;
	} iocs_state_s;

endpackage : iocs_pkg

`default_nettype wire

// file: hdl/iocs_top.sv
// internal oscillator clock switch: source select, glitch-free change-over, status
// Behaviour
// - powered-down target runs start-up delay first
// - after start-up, wait for old clock falling
// - hold clock low until new clock rises
// - update status flags, then switch completes
// - same-oscillator frequency change skips start-up
// - source field 00 uses configuration clock
// - source field 01 selects secondary oscillator
// - source field 1x uses internal block
// - reset clears source field to zero
// - delays: LF one edge, HF 2us, external two
// - frequency field bits 6..3 map divider taps
// - codes 1010..1000 are HF-derived duplicates
// - frequency field resets to 0111
// - status bit 4 shows HF oscillator ready
// - status bit 1 shows LF oscillator ready
// - status bit 0 shows HF stable driving
// - unimplemented bits read as zero
// - stable flag only within tolerance indication
//
// Chosen here: the register offsets and the strobed register port.
`default_nettype none
`include "iocs_cfg.svh"

module iocs_top (
	input wire logic i_mclk,
	input wire logic i_reset_n,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	input wire logic i_cfg_clk,
	input wire logic i_sec_clk,
	input wire logic i_hf_clk,
	input wire logic i_lf_clk,
	input wire logic i_hf_in_tol,
	output logic o_hf_osc_en,
	output logic o_lf_osc_en,
	output logic o_sysclk,
	output logic o_switch_busy,
	output iocs_pkg::iocs_src_e o_active_src
);
	import iocs_pkg::*;

	// ------------------------------------------------------------------
	// decode helpers
	// ------------------------------------------------------------------
	function automatic iocs_src_e src_of(input logic [1:0] scs, input logic [3:0] ircf);
		iocs_src_e s;
		s = SRC_CFG;
		if (scs[`IOCS_SCS_INT_BIT]) begin
			if (ircf < `IOCS_IRCF_LF_TOP) begin
				s = SRC_LF;
			end else begin
				s = SRC_HF;
			end
		end else if (scs == `IOCS_SCS_SECONDARY) begin
			s = SRC_SEC;
		end
		return s;
	endfunction : src_of

	function automatic logic [3:0] tap_of(input logic [3:0] ircf);
		logic [3:0] t;
		t = `IOCS_TAP_SLOW;
		if (ircf >= `IOCS_IRCF_HF_LOW) begin
			t = `IOCS_TAP_HF_BASE - ircf;
		end else if (ircf >= `IOCS_IRCF_MID_LOW) begin
			t = `IOCS_TAP_MID_BASE - ircf;
		end
		return t;
	endfunction : tap_of

	function automatic logic level_of(input iocs_src_e src, input logic [3:0] tap,
			input logic [4:0] filt, input logic [9:0] taps);
		logic l;
		l = 1'b0;
		case (src)
			SRC_CFG: l = filt[`IOCS_PIN_CFG];
			SRC_SEC: l = filt[`IOCS_PIN_SEC];
			SRC_LF: l = filt[`IOCS_PIN_LF];
			SRC_HF: l = taps[tap];
			default: l = 1'b0;
		endcase
		return l;
	endfunction : level_of

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	iocs_state_s q;
	iocs_state_s d;
	logic [4:0] agree;
	logic [4:0] rise;
	logic [9:0] taps;
	logic act_lvl;
	logic tgt_lvl;
	logic tgt_rise;
	iocs_src_e want_src;
	logic [3:0] want_tap;

	always_comb begin
		d = q;
		// pins pass three flops; a change counts when second and third agree
		d.sync1 = {i_hf_in_tol, i_lf_clk, i_hf_clk, i_sec_clk, i_cfg_clk};
		d.sync2 = q.sync1;
		d.sync3 = q.sync2;
		agree = ~(q.sync2 ^ q.sync3);
		d.filt = (agree & q.sync3) | (~agree & q.filt);
		d.prev = q.filt;
		rise = q.filt & ~q.prev;

		// postscaler runs only while the HF oscillator is powered
		if (q.hf_on && rise[`IOCS_PIN_HF]) begin
			d.div = q.div + 9'h001;
		end
		taps = {q.div, q.filt[`IOCS_PIN_HF]};

		act_lvl = level_of(q.act_src, q.act_tap, q.filt, taps);
		tgt_lvl = level_of(q.tgt_src, q.tgt_tap, q.filt, taps);
		tgt_rise = tgt_lvl & ~q.tgt_prev;
		d.act_prev = act_lvl;

		want_src = src_of(q.scs, q.ircf);
		want_tap = (want_src == SRC_HF) ? tap_of(q.ircf) : 4'h0;

		// output follows the active source outside the change-over
		d.sysclk = act_lvl;

		// --------------------------------------------------------------
		// switch sequence
		// --------------------------------------------------------------
		case (q.fsm)
			ST_IDLE: begin
				if (want_src != q.act_src || want_tap != q.act_tap) begin
					d.tgt_src = want_src;
					d.tgt_tap = want_tap;
					d.cnt = 7'h00;
					if (want_src == SRC_HF && q.hf_on) begin
						d.fsm = ST_WAIT_FALL;
					end else if (want_src == SRC_LF && q.lf_on) begin
						d.fsm = ST_WAIT_FALL;
					end else begin
						d.fsm = ST_STARTUP;
						if (want_src == SRC_HF) begin
							d.hf_on = 1'b1;
						end
						if (want_src == SRC_LF) begin
							d.lf_on = 1'b1;
						end
					end
				end
			end
			ST_STARTUP: begin
				// old clock keeps driving the output meanwhile
				case (q.tgt_src)
					SRC_HF: begin
						d.cnt = q.cnt + 7'h01;
						if (q.cnt == 7'(`IOCS_HF_STARTUP_CYC - 1)) begin
							d.fsm = ST_WAIT_FALL;
						end
					end
					SRC_LF: begin
						if (tgt_rise) begin
							d.cnt = q.cnt + 7'h01;
							if (q.cnt + 7'h01 >= `IOCS_LF_STARTUP_EDGES) begin
								d.fsm = ST_WAIT_FALL;
							end
						end
					end
					default: begin
						if (tgt_rise) begin
							d.cnt = q.cnt + 7'h01;
							if (q.cnt + 7'h01 >= `IOCS_EXT_STARTUP_EDGES) begin
								d.fsm = ST_WAIT_FALL;
							end
						end
					end
				endcase
			end
			ST_WAIT_FALL: begin
				if (q.act_prev && !act_lvl) begin
					d.sysclk = 1'b0;
					d.fsm = ST_WAIT_RISE;
				end
			end
			ST_WAIT_RISE: begin
				// parked low: no partial phase of either source escapes
				d.sysclk = 1'b0;
				if (tgt_rise) begin
					d.sysclk = 1'b1;
					d.act_src = q.tgt_src;
					d.act_tap = q.tgt_tap;
					d.fsm = ST_UPDATE;
				end
			end
			ST_UPDATE: begin
				// unused oscillators drop only after the new one is active
				d.hf_on = (q.act_src == SRC_HF);
				d.lf_on = (q.act_src == SRC_LF);
				d.hf_flag = (q.act_src == SRC_HF);
				d.lf_flag = (q.act_src == SRC_LF);
				d.fsm = ST_IDLE;
			end
			default: begin
				d.fsm = ST_IDLE;
			end
		endcase

		// target edge tracking follows the target latched this cycle
		d.tgt_prev = level_of(d.tgt_src, d.tgt_tap, q.filt, taps);

		// --------------------------------------------------------------
		// register port
		// --------------------------------------------------------------
		if (i_wr && i_addr == `IOCS_OSC_CONTROL_ADDR) begin
			d.ircf = i_wdata[`IOCS_IRCF_MSB:`IOCS_IRCF_LSB];
			d.scs = i_wdata[`IOCS_SCS_MSB:`IOCS_SCS_LSB];
		end
		d.rdata = 8'h00;
		if (i_rd) begin
			case (i_addr)
				`IOCS_OSC_CONTROL_ADDR: begin
					d.rdata[`IOCS_IRCF_MSB:`IOCS_IRCF_LSB] = q.ircf;
					d.rdata[`IOCS_SCS_MSB:`IOCS_SCS_LSB] = q.scs;
				end
				`IOCS_OSC_STATUS_ADDR: begin
					d.rdata[`IOCS_STAT_HF_READY_BIT] = q.hf_flag;
					d.rdata[`IOCS_STAT_LF_READY_BIT] = q.lf_flag;
					// tolerance pin alone is not enough: HF must also drive
					d.rdata[`IOCS_STAT_HF_STABLE_BIT] = q.hf_flag
						& q.filt[`IOCS_PIN_TOL];
				end
				default: begin
					d.rdata = 8'h00;
				end
			endcase
		end
	end

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			q <= '0;
			q.scs <= `IOCS_SCS_RESET;
			q.ircf <= `IOCS_IRCF_RESET;
		end else begin
			q <= d;
		end
	end

	// ------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------
	assign o_rdata = q.rdata;
	assign o_sysclk = q.sysclk;
	assign o_hf_osc_en = q.hf_on;
	assign o_lf_osc_en = q.lf_on;
	assign o_switch_busy = (q.fsm != ST_IDLE);
	assign o_active_src = q.act_src;

endmodule : iocs_top

`default_nettype wire

// file: verif/iocs_chk_sva.sv
// assertions on the clock switch ports
`default_nettype none
`include "iocs_cfg.svh"

module iocs_chk (
	input wire logic i_mclk,
	input wire logic i_reset_n,
	input wire logic [7:0] i_addr,
	input wire logic i_rd,
	input wire logic [7:0] o_rdata,
	input wire logic o_hf_osc_en,
	input wire logic o_sysclk,
	input wire logic o_switch_busy,
	input wire iocs_pkg::iocs_src_e o_active_src
);
	import iocs_pkg::*;
	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking @(posedge i_mclk);
	endclocking
	default disable iff (!i_reset_n);
	sequence ctl_rd;
		$past(i_rd) && $past(i_addr) == `IOCS_OSC_CONTROL_ADDR;
	endsequence
	sequence st_rd;
		$past(i_rd) && $past(i_addr) == `IOCS_OSC_STATUS_ADDR;
	endsequence
	sequence hf_up;
		$rose(o_hf_osc_en);
	endsequence
	rd_idle_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
		else $error("read data outside its cycle");
	ctl_zero_a: assert property (ctl_rd |-> !o_rdata[7] && !o_rdata[2])
		else $error("control unused bits set");
	stat_zero_a: assert property (st_rd |-> (o_rdata & 8'hec) == 8'h00)
		else $error("status unused bits set");
	stable_ready_a: assert property (st_rd ##0 o_rdata[0] |-> o_rdata[4])
		else $error("stable without ready");
	new_rise_a: assert property ($changed(o_active_src) |-> o_sysclk && !$past(o_sysclk))
		else $error("change-over not at a rising edge");
	upd_busy_a: assert property ($changed(o_active_src) |-> o_switch_busy)
		else $error("switch ended before status update");
	switch_bound_a: assert property ($rose(o_switch_busy) |-> ##[1:700] !o_switch_busy)
		else $error("switch never completed");
	hf_start_a: assert property (hf_up |-> ##96 o_active_src != SRC_HF)
		else $error("hf start-up delay cut short");
	hf_hold_a: assert property (!o_switch_busy && o_active_src == SRC_HF |-> o_hf_osc_en)
		else $error("active hf oscillator unpowered");
endmodule : iocs_chk

bind iocs_top iocs_chk u_chk (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_addr(i_addr),
	.i_rd(i_rd), .o_rdata(o_rdata), .o_hf_osc_en(o_hf_osc_en), .o_sysclk(o_sysclk),
	.o_switch_busy(o_switch_busy), .o_active_src(o_active_src));
`default_nettype wire

// file: verif/iocs_top_test.sv
// testbench for the internal oscillator clock switch
`default_nettype none
`include "iocs_cfg.svh"
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
	$display("MISMATCH %s exp %h got %h", n, e, g); end end

module iocs_top_test;
	timeunit 1ns;
	timeprecision 1ns;
	import iocs_pkg::*;
	// ----------------------------------------
	// stimulus and checks
	// ----------------------------------------
	localparam logic [7:0] ctl = `IOCS_OSC_CONTROL_ADDR;
	localparam logic [7:0] st = `IOCS_OSC_STATUS_ADDR;
	logic i_mclk = 1'b0, i_reset_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0, i_hf_in_tol = 1'b1;
	logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, o_rdata;
	logic [5:0] ph = 6'h00;
	logic o_hf_osc_en, o_lf_osc_en, o_sysclk, o_switch_busy;
	iocs_src_e o_active_src;
	int error_cnt = 0, check_count = 0, n;
	initial begin
		forever #10 i_mclk = ~i_mclk;
	end
	// oscillators as slow divided levels, far below the sampling rate
	always @(posedge i_mclk) begin
		ph <= ph + 6'h01;
	end
	iocs_top uut (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_cfg_clk(ph[3]), .i_sec_clk(ph[4]),
		.i_hf_clk(ph[2]), .i_lf_clk(ph[5]), .i_hf_in_tol(i_hf_in_tol),
		.o_hf_osc_en(o_hf_osc_en), .o_lf_osc_en(o_lf_osc_en), .o_sysclk(o_sysclk),
		.o_switch_busy(o_switch_busy), .o_active_src(o_active_src));
	task automatic summarize();
		if (error_cnt == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : summarize
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_mclk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_mclk);
		i_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input string s);
		@(posedge i_mclk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_mclk);
		i_rd <= 1'b0;
		#1;
		`CHK(s, e, o_rdata)
	endtask : rd
	// counts busy cycles; bounded so a stuck switch ends the run
	task automatic wait_sw(output int c);
		int k;
		c = 0;
		for (k = 0; k < 2000 && !(c > 0 && o_switch_busy === 1'b0); k++) begin
			@(posedge i_mclk);
			#1;
			if (o_switch_busy === 1'b1) c++;
		end
		if (k == 2000) begin
			error_cnt++;
			summarize();
		end
	endtask : wait_sw
	initial begin
		repeat (3) @(posedge i_mclk);
		i_reset_n <= 1'b1;
		rd(ctl, 8'h38, "ctrl reset");
		rd(st, 8'h00, "stat reset");
		`CHK("src reset", SRC_CFG, o_active_src)
		wr(ctl, 8'hfe);
		wait_sw(n);
		rd(ctl, 8'h7a, "ctrl mask");
		`CHK("hf delay", 1'b1, n > 100)
		`CHK("src hf", SRC_HF, o_active_src)
		`CHK("hf en", 1'b1, o_hf_osc_en)
		rd(st, 8'h11, "stat hf");
		i_hf_in_tol <= 1'b0;
		repeat (8) @(posedge i_mclk);
		rd(st, 8'h10, "stat tol");
		i_hf_in_tol <= 1'b1;
		wr(ctl, 8'h72);
		wait_sw(n);
		`CHK("same osc", 1'b1, n < 100)
		wr(ctl, 8'h52);
		wait_sw(n);
		`CHK("src dup", SRC_HF, o_active_src)
		wr(ctl, 8'h02);
		wait_sw(n);
		`CHK("src lf", SRC_LF, o_active_src)
		`CHK("lf en", 1'b1, o_lf_osc_en)
		`CHK("hf off", 1'b0, o_hf_osc_en)
		rd(st, 8'h02, "stat lf");
		wr(ctl, 8'h01);
		wait_sw(n);
		`CHK("src sec", SRC_SEC, o_active_src)
		wr(ctl, 8'h00);
		wait_sw(n);
		`CHK("src cfg", SRC_CFG, o_active_src)
		wr(8'h10, 8'hff);
		wr(st, 8'hff);
		rd(8'h10, 8'h00, "unmapped");
		rd(st, 8'h00, "stat ro");
		rd(ctl, 8'h00, "ctrl kept");
		wr(ctl, 8'h7a);
		repeat (20) @(posedge i_mclk);
		i_reset_n <= 1'b0;
		repeat (3) @(posedge i_mclk);
		i_reset_n <= 1'b1;
		rd(ctl, 8'h38, "ctrl rerun");
		`CHK("src rerun", SRC_CFG, o_active_src)
		summarize();
	end
endmodule : iocs_top_test
`default_nettype wire
